// file: psel_pkg.sv
// Constants shared by the parameter set selector
package psel_pkg;
	localparam int unsigned PSEL_NSETS     = 8;
	localparam int unsigned PSEL_AW        = 8;
	localparam int unsigned PSEL_CW        = 4;
	localparam int unsigned PSEL_NW        = 3;
	localparam logic [7:0]  PSEL_OFS_OVR   = 8'h00;
	localparam logic [7:0]  PSEL_OFS_TGT   = 8'h04;
	localparam logic [7:0]  PSEL_OFS_CNT   = 8'h08;
	localparam logic [7:0]  PSEL_OFS_RMT   = 8'h0C;
	localparam logic [7:0]  PSEL_OFS_ACT   = 8'h10;
	localparam logic [7:0]  PSEL_OFS_STAT  = 8'h14;
	localparam logic [7:0]  PSEL_OFS_LVL   = 8'h18;
	localparam int unsigned PSEL_F_NCFG    = 0;
	localparam int unsigned PSEL_F_FORCE   = 1;
	localparam int unsigned PSEL_F_PRIO    = 2;
	localparam logic [3:0]  PSEL_CODE_NONE = 4'h0;
	localparam logic [3:0]  PSEL_ACT_RST   = 4'h1;
	localparam logic [2:0]  PSEL_CNT_RST   = 3'h0;
	localparam logic [31:0] PSEL_DAT_ZERO  = 32'h0000_0000;
endpackage : psel_pkg

// file: psel_act_if.sv
// Interface joining input conditioning, rank encoder and selector core
`timescale 1ns/10ps
`default_nettype none
interface psel_act_if #(parameter int unsigned N = 8);
	logic [N-1:0] lvl;
	logic [N-1:0] rise;
	logic [N-1:0] vec;
	logic         hit;
	logic [2:0]   idx;
	modport sync (output lvl, output rise);
	modport enc  (input vec, output hit, output idx);
	modport ctl  (input lvl, input rise, input hit, input idx, output vec);
endinterface : psel_act_if
`default_nettype wire

// file: psel_sync.sv
// Two-stage synchroniser and rising-edge detect for activation inputs
`timescale 1ns/10ps
`default_nettype none
module psel_sync import psel_pkg::*; #(
	parameter int unsigned N = PSEL_NSETS
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         ce_i,
	input  wire logic [N-1:0] pin_i,
	psel_act_if.sync          a
);
	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
		logic [N-1:0] s3;
	} psel_sync_t;
	psel_sync_t s_r;
	psel_sync_t s_nxt;
	always_comb begin
		s_nxt    = s_r;
		s_nxt.s1 = pin_i;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end
	// Edge taken from stages two and three so stage one feeds nothing else
	for (genvar g = 0; g < N; g++) begin : g_bit
		assign a.lvl[g]  = s_r.s2[g];
		assign a.rise[g] = s_r.s2[g] & ~s_r.s3[g];
	end
endmodule : psel_sync
`default_nettype wire

// file: psel_rank.sv
// Rank encoder: topmost requesting set, set one ranked first
`timescale 1ns/10ps
`default_nettype none
module psel_rank import psel_pkg::*; #(
	parameter int unsigned N = PSEL_NSETS
) (
	psel_act_if.enc a
);
	always_comb begin
		a.hit = 1'b0;
		a.idx = 3'h0;
		for (int i = N - 1; i >= 0; i--) begin
			if (a.vec[i]) begin
				a.hit = 1'b1;
				a.idx = 3'(i);
			end
		end
	end
endmodule : psel_rank
`default_nettype wire

// file: psel_top.sv
// Parameter set selector core with classic Wishbone register slave
//
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module psel_top import psel_pkg::*; #(
	parameter int unsigned N_SETS = PSEL_NSETS
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              ce_i,
	input  wire logic [N_SETS-1:0] act_req_i,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [PSEL_AW-1:0] wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic                   wb_ack_o,
	output logic [31:0]            wb_dat_o,
	output logic [3:0]             active_set_o,
	output logic                   set_change_o,
	output logic [N_SETS-1:0]      set_enabled_o,
	output logic [N_SETS-1:0]      default_load_o,
	output logic                   override_enable_o,
	output logic [2:0]             fail_o
);
	if (N_SETS < 2 || N_SETS > PSEL_NSETS) begin : g_chk
		$error("psel_top: N_SETS must lie between 2 and 8");
	end

	typedef struct packed {
		logic              ack;
		logic [31:0]       rdat;
		logic              ovr;
		logic [3:0]        tgt;
		logic [2:0]        cnt;
		logic [3:0]        rmt;
		logic [3:0]        act;
		logic [2:0]        fail;
		logic              chg;
		logic [N_SETS-1:0] en;
		logic [N_SETS-1:0] ld;
	} psel_core_t;

	psel_core_t s_r;
	psel_core_t s_nxt;

	psel_act_if #(.N(N_SETS)) a ();

	psel_sync #(.N(N_SETS)) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.pin_i (act_req_i),
		.a     (a)
	);

	psel_rank #(.N(N_SETS)) u_rank (
		.a (a)
	);

	// Enabled-set mask for a set count code
	function automatic logic [N_SETS-1:0] en_mask(input logic [2:0] cnt);
		logic [N_SETS-1:0] m;
		m = '0;
		for (int i = 0; i < N_SETS; i++) begin
			m[i] = (3'(i) <= cnt);
		end
		return m;
	endfunction : en_mask

	// True when a code names an existing, enabled set
	function automatic logic code_ok(input logic [3:0] code, input logic [2:0] cnt);
		logic ok;
		ok = (code != PSEL_CODE_NONE) && (code <= 4'(N_SETS));
		if (ok) begin
			ok = (3'(code - 4'h1) <= cnt);
		end
		return ok;
	endfunction : code_ok

	logic [N_SETS-1:0] cfg;
	logic [2:0]        cnt_max;
	assign cfg     = en_mask(s_r.cnt);
	assign cnt_max = 3'(N_SETS - 1);
	// Unconfigured inputs never take part in ranking
	assign a.vec   = a.lvl & cfg;

	logic       req;
	logic       wr;
	logic [3:0] wcode;
	logic [2:0] wcnt;
	logic       f_ncfg;
	logic       f_force;
	logic       f_prio;

	always_comb begin
		s_nxt   = s_r;
		s_nxt.ld = '0;
		f_ncfg  = 1'b0;
		f_force = 1'b0;
		f_prio  = 1'b0;
		req     = wb_cyc_i & wb_stb_i;
		// Write lands on the edge where the master sees ack
		wr      = req & s_r.ack & wb_we_i & wb_sel_i[0];
		wcode   = wb_dat_i[3:0];
		wcnt    = wb_dat_i[2:0];
		s_nxt.ack = req & ~s_r.ack;

		if (req && !s_r.ack) begin
			case (wb_adr_i)
				PSEL_OFS_OVR:  s_nxt.rdat = {31'h0000_0000, s_r.ovr};
				PSEL_OFS_TGT:  s_nxt.rdat = {28'h000_0000, s_r.tgt};
				PSEL_OFS_CNT:  s_nxt.rdat = {29'h0000_0000, s_r.cnt};
				PSEL_OFS_RMT:  s_nxt.rdat = {28'h000_0000, s_r.rmt};
				PSEL_OFS_ACT:  s_nxt.rdat = {28'h000_0000, s_r.act};
				PSEL_OFS_STAT: s_nxt.rdat = {29'h0000_0000, s_r.fail};
				PSEL_OFS_LVL:  s_nxt.rdat = 32'(a.lvl);
				default:       s_nxt.rdat = PSEL_DAT_ZERO;
			endcase
		end

		// Local inputs: topmost held level wins, pulses latch while high and hold after release
		if (!s_r.ovr && a.hit) begin
			s_nxt.act = 4'({1'b0, a.idx}) + 4'h1;
		end
		// No request keeps the last set: act simply holds
		if (|(a.rise & ~cfg)) begin
			f_ncfg = 1'b1;
		end
		for (int i = 0; i < N_SETS; i++) begin
			if (!s_r.ovr && a.rise[i] && cfg[i] && a.hit && 3'(i) > a.idx) begin
				f_prio = 1'b1;
			end
		end

		if (wr) begin
			case (wb_adr_i)
				PSEL_OFS_OVR: begin
					s_nxt.ovr = wb_dat_i[0];
				end
				PSEL_OFS_TGT: begin
					s_nxt.tgt = wcode;
					if (wcode != PSEL_CODE_NONE) begin
						if (s_r.ovr && code_ok(wcode, s_r.cnt)) begin
							s_nxt.act = wcode;
						end else begin
							f_force = 1'b1;
						end
					end
				end
				PSEL_OFS_CNT: begin
					// Codes past the last built set are clamped
					s_nxt.cnt = (wcnt > cnt_max) ? cnt_max : wcnt;
					s_nxt.ld  = en_mask(s_nxt.cnt) & ~cfg;
					// Checked on the next value so a same-cycle input pick is caught too
					if (3'(s_nxt.act - 4'h1) > s_nxt.cnt) begin
						// A disabled active set falls back to set one
						s_nxt.act = PSEL_ACT_RST;
					end
				end
				PSEL_OFS_RMT: begin
					s_nxt.rmt = wcode;
					if (wcode != PSEL_CODE_NONE) begin
						if (!s_r.ovr) begin
							f_force = 1'b1;
						end else if (!code_ok(wcode, s_r.cnt)) begin
							f_ncfg = 1'b1;
						end else if (a.hit && 3'(wcode - 4'h1) > a.idx) begin
							f_prio = 1'b1;
						end else begin
							s_nxt.act = wcode;
						end
					end
				end
				PSEL_OFS_STAT: begin
					s_nxt.fail = s_r.fail & ~wb_dat_i[2:0];
				end
				default: begin
				end
			endcase
		end

		// New failures win over a clear in the same cycle
		s_nxt.fail[PSEL_F_NCFG]  = s_nxt.fail[PSEL_F_NCFG] | f_ncfg;
		s_nxt.fail[PSEL_F_FORCE] = s_nxt.fail[PSEL_F_FORCE] | f_force;
		s_nxt.fail[PSEL_F_PRIO]  = s_nxt.fail[PSEL_F_PRIO] | f_prio;
		s_nxt.en  = en_mask(s_nxt.cnt);
		s_nxt.chg = (s_nxt.act != s_r.act);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r      <= '0;
			s_r.act  <= PSEL_ACT_RST;
			s_r.cnt  <= PSEL_CNT_RST;
			s_r.tgt  <= PSEL_CODE_NONE;
			s_r.rmt  <= PSEL_CODE_NONE;
			s_r.ovr  <= 1'b0;
			s_r.en   <= {{(N_SETS-1){1'b0}}, 1'b1};
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end

	assign wb_ack_o          = s_r.ack;
	assign wb_dat_o          = s_r.rdat;
	assign active_set_o      = s_r.act;
	assign set_change_o      = s_r.chg;
	assign set_enabled_o     = s_r.en;
	assign default_load_o    = s_r.ld;
	assign override_enable_o = s_r.ovr;
	assign fail_o            = s_r.fail;
endmodule : psel_top
`default_nettype wire

// file: psel_sva.sv
// Port-level checker for the parameter set selector
`timescale 1ns/10ps
`default_nettype none
module psel_sva import psel_pkg::*; #(
	parameter int unsigned N_SETS = PSEL_NSETS
) (
	input wire logic              clk_i,
	input wire logic              rst_i,
	input wire logic              wb_cyc_i,
	input wire logic              wb_stb_i,
	input wire logic              wb_we_i,
	input wire logic              wb_ack_o,
	input wire logic [3:0]        active_set_o,
	input wire logic              set_change_o,
	input wire logic [N_SETS-1:0] set_enabled_o,
	input wire logic [N_SETS-1:0] default_load_o,
	input wire logic              override_enable_o,
	input wire logic [2:0]        fail_o,
	input wire logic [N_SETS-1:0] act_req_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_one; (act_req_i[0] && !override_enable_o) [*3]; endsequence
	// Reset guards: values sampled during reset are not caused by the bus
	property p_ack; s_req |=> wb_ack_o ##1 !wb_ack_o; endproperty
	property p_chg; !$past(rst_i) |-> set_change_o == !$stable(active_set_o); endproperty
	property p_rng; active_set_o inside {[1:8]} && set_enabled_o[active_set_o - 4'h1]; endproperty
	property p_en1; set_enabled_o[0]; endproperty
	property p_dl; !$past(rst_i) |-> default_load_o == (set_enabled_o & ~$past(set_enabled_o));
	endproperty
	property p_ovr; !$past(rst_i) && !$stable(override_enable_o) |-> $past(wb_ack_o) &&
		$past(wb_we_i); endproperty
	property p_stk; !$past(rst_i) && |($past(fail_o) & ~fail_o) |-> $past(wb_ack_o) &&
		$past(wb_we_i); endproperty
	property p_one; s_one |=> active_set_o == 4'h1; endproperty
	a_ack: assert property (p_ack) else $error("bus ack timing wrong");
	a_chg: assert property (p_chg) else $error("change pulse mismatch");
	a_rng: assert property (p_rng) else $error("active set not enabled");
	a_en1: assert property (p_en1) else $error("set one disabled");
	a_dl: assert property (p_dl) else $error("default load mismatch");
	a_ovr: assert property (p_ovr) else $error("override changed without write");
	a_stk: assert property (p_stk) else $error("fail flag cleared without write");
	a_one: assert property (p_one) else $error("held set one not active");
endmodule : psel_sva
bind psel_top psel_sva #(.N_SETS(N_SETS)) u_psel_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_ack_o, .active_set_o, .set_change_o, .set_enabled_o, .default_load_o,
	.override_enable_o, .fail_o, .act_req_i);
`default_nettype wire

// file: psel_far.sv
// Far-side model: activation levels and stretched activation pulses
`timescale 1ns/10ps
`default_nettype none
module psel_far import psel_pkg::*; (
	input  wire logic       clk_i,
	input  wire logic [7:0] hold_i,
	input  wire logic [7:0] pulse_i,
	output logic      [7:0] act_req_o
);
	logic [7:0] str_r = 8'h00;
	logic [1:0] cnt_r = 2'h0;
	// Pulses last three cycles so they survive the two-stage input sync
	always_ff @(posedge clk_i) begin
		str_r <= (|pulse_i) ? pulse_i : ((cnt_r == 2'h0) ? 8'h00 : str_r);
		cnt_r <= (|pulse_i) ? 2'h2 : ((cnt_r == 2'h0) ? 2'h0 : cnt_r - 2'h1);
	end
	assign act_req_o = hold_i | str_r;
endmodule : psel_far
`default_nettype wire

// file: psel_top_test.sv
// Self-checking bench for the parameter set selector
`timescale 1ns/10ps
`default_nettype none
module psel_top_test import psel_pkg::*;;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc   = 1'b0;
	logic        ce    = 1'b1;
	logic [7:0]  en;
	logic        ovr;
	logic [2:0]  fail;
	logic [31:0] exp_v;
	logic        we    = 1'b0;
	logic [7:0]  adr   = 8'h00;
	logic [7:0]  hold  = 8'h00;
	logic [7:0]  pulse = 8'h00;
	logic [31:0] wdat  = 32'h0000_0000;
	logic [7:0]  act;
	logic [31:0] rdat;
	logic        ack;
	logic [3:0]  aset;
	int          errors = 0;
	int          n_compared = 0;
	int          cyc_n = 0;
	logic [31:0] exp_q[$];
	psel_far u_psel_far (.clk_i, .hold_i(hold), .pulse_i(pulse), .act_req_o(act));
	psel_top u_psel_top (.clk_i, .rst_i, .ce_i(ce), .act_req_i(act), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
		.wb_ack_o(ack), .wb_dat_o(rdat), .active_set_o(aset), .set_change_o(),
		.set_enabled_o(en), .default_load_o(), .override_enable_o(ovr), .fail_o(fail));
	initial forever #20 clk_i = ~clk_i;
	task automatic check(input logic [31:0] seen, input logic [31:0] expd);
		n_compared++;
		if (seen !== expd) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expd);
		end
	endtask : check
	task automatic close_out();
		$display("compared=%0d errors=%0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask : wt
	// Request held until the edge that samples ack, then one idle cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk_i iff ack);
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		wb(1'b0, a, PSEL_DAT_ZERO);
	endtask : rd
	always @(posedge clk_i) begin
		cyc_n++;
		// Status outputs must agree with the register seen at the same ack
		if (ack && !we) begin
			exp_v = exp_q.pop_front();
			check(rdat, exp_v);
			if (adr == PSEL_OFS_ACT)
				check(32'(aset), exp_v);
			if (adr == PSEL_OFS_CNT)
				check(32'(en), 32'((16'h0002 << exp_v[2:0]) - 16'h0001));
			if (adr == PSEL_OFS_OVR)
				check(32'(ovr), exp_v);
			if (adr == PSEL_OFS_STAT)
				check(32'(fail), exp_v);
		end
		if (cyc_n == 2000) begin
			errors++;
			close_out();
		end
	end
	initial begin
		logic [7:0] v;
		int e;
		void'($urandom(11));
		wt(8);
		rst_i <= 1'b0;
		wt(1);
		rd(PSEL_OFS_ACT, 32'h0000_0001);
		rd(PSEL_OFS_OVR, PSEL_DAT_ZERO);
		rd(PSEL_OFS_TGT, PSEL_DAT_ZERO);
		rd(PSEL_OFS_CNT, PSEL_DAT_ZERO);
		rd(PSEL_OFS_RMT, PSEL_DAT_ZERO);
		rd(8'h1C, PSEL_DAT_ZERO);
		wr(PSEL_OFS_CNT, 32'h0000_0007);
		rd(PSEL_OFS_CNT, 32'h0000_0007);
		// Set eight always held: it must never mask a higher set
		repeat (6) begin
			v = 8'($urandom) | 8'h80;
			for (int k = 7; k >= 0; k--)
				if (v[k])
					e = k + 1;
			hold <= v;
			wt(6);
			rd(PSEL_OFS_ACT, 32'(e));
		end
		hold <= 8'h00;
		for (int k = 4; k < 7; k += 2) begin
			pulse <= 8'(1 << k);
			wt(1);
			pulse <= 8'h00;
			wt(8);
			rd(PSEL_OFS_ACT, 32'(k + 1));
		end
		hold <= 8'h02;
		wt(6);
		wr(PSEL_OFS_OVR, 32'h0000_0001);
		rd(PSEL_OFS_OVR, 32'h0000_0001);
		wr(PSEL_OFS_STAT, 32'h0000_0007);
		wr(PSEL_OFS_RMT, 32'h0000_0004);
		rd(PSEL_OFS_ACT, 32'h0000_0002);
		rd(PSEL_OFS_STAT, 32'h0000_0004);
		wr(PSEL_OFS_RMT, 32'h0000_0001);
		rd(PSEL_OFS_ACT, 32'h0000_0001);
		wr(PSEL_OFS_TGT, 32'h0000_0008);
		wr(PSEL_OFS_TGT, PSEL_DAT_ZERO);
		rd(PSEL_OFS_ACT, 32'h0000_0008);
		hold <= 8'h00;
		wt(3);
		wr(PSEL_OFS_OVR, PSEL_DAT_ZERO);
		wt(6);
		rd(PSEL_OFS_ACT, 32'h0000_0008);
		wr(PSEL_OFS_STAT, 32'h0000_0007);
		wr(PSEL_OFS_TGT, 32'h0000_0003);
		rd(PSEL_OFS_ACT, 32'h0000_0008);
		rd(PSEL_OFS_STAT, 32'h0000_0002);
		wr(PSEL_OFS_OVR, 32'h0000_0001);
		hold <= 8'h04;
		wt(6);
		rd(PSEL_OFS_ACT, 32'h0000_0008);
		wr(PSEL_OFS_OVR, PSEL_DAT_ZERO);
		wt(2);
		rd(PSEL_OFS_ACT, 32'h0000_0003);
		wr(PSEL_OFS_CNT, 32'h0000_0001);
		rd(PSEL_OFS_ACT, 32'h0000_0001);
		rd(PSEL_OFS_CNT, 32'h0000_0001);
		// Enable low freezes the input stages: the new level waits for it
		ce <= 1'b0;
		hold <= 8'h02;
		wt(6);
		ce <= 1'b1;
		rd(PSEL_OFS_ACT, 32'h0000_0001);
		rd(PSEL_OFS_ACT, 32'h0000_0002);
		close_out();
	end
endmodule : psel_top_test
`default_nettype wire
